// file: pkg/dmad_pkg.sv
// package with address map constants for the data memory address decoder
package dmad_pkg;
    localparam int unsigned DMAD_HALF = 128;
    localparam logic [7:0] DMAD_BANK_END = 8'h20;
    localparam logic [7:0] DMAD_BIT_END = 8'h30;
    localparam logic [15:0] DMAD_XMEM_SIZE = 16'h2000;
    localparam logic [17:0] DMAD_RSV_LO = 18'h1fc00;
    localparam logic [17:0] DMAD_RSV_HI = 18'h1ffff;
    localparam logic [17:0] DMAD_SMALL_END = 18'h0ffff;
    localparam logic [17:0] DMAD_SCR_LO = 18'h20000;
    localparam logic [17:0] DMAD_SCR_HI = 18'h200ff;
    localparam int unsigned DMAD_SECTOR_BITS = 10;
    localparam int unsigned DMAD_SCR_SECTOR_BITS = 7;

    typedef enum logic [1:0] {
        DMAD_MAP_ONCHIP,
        DMAD_MAP_OFFCHIP,
        DMAD_MAP_SPLIT,
        DMAD_MAP_SPLIT2
    } dmad_map_t;

    typedef enum logic [2:0] {
        DMAD_TGT_NONE,
        DMAD_TGT_IRAM,
        DMAD_TGT_SPECIAL,
        DMAD_TGT_XMEM_ONCHIP,
        DMAD_TGT_EXT_PORT,
        DMAD_TGT_FLASH,
        DMAD_TGT_SCRATCH
    } dmad_tgt_t;
endpackage

// file: design/dmad_flash_dec.sv
// flash program space decode with reserved and scratchpad areas
`timescale 1ns/10ps
module dmad_flash_dec
    import dmad_pkg::*;
#(
    parameter bit BANKED = 1'b1
) (
    input wire logic [17:0] addr_i,
    input wire logic is_data_i,
    output logic hit_o,
    output logic reserved_o,
    output logic scratch_o,
    output logic [7:0] sector_o
);
    always_comb begin
        hit_o = 1'b0;
        reserved_o = 1'b0;
        scratch_o = 1'b0;
        sector_o = addr_i[17:10];
        if (addr_i >= DMAD_SCR_LO && addr_i <= DMAD_SCR_HI) begin
            scratch_o = is_data_i;
            reserved_o = !is_data_i;
            sector_o = {7'h00, addr_i[DMAD_SCR_SECTOR_BITS]};
        end else if (BANKED) begin
            if (addr_i >= DMAD_RSV_LO && addr_i <= DMAD_RSV_HI) begin
                reserved_o = 1'b1;
            end else begin
                hit_o = 1'b1;
            end
        end else if (addr_i <= DMAD_SMALL_END) begin
            hit_o = 1'b1;
        end else begin
            reserved_o = 1'b1;
        end
    end
endmodule

// file: design/dmad_top.sv
// data and program memory address decoder top
`timescale 1ns/10ps
module dmad_top
    import dmad_pkg::*;
#(
    parameter bit BANKED = 1'b1
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    // internal data access
    input wire logic iacc_i,
    input wire logic iacc_direct_i,
    input wire logic iacc_bit_i,
    input wire logic [7:0] iaddr_i,
    input wire logic [1:0] bank_sel_i,
    // external data access
    input wire logic xacc_i,
    input wire logic [15:0] xaddr_i,
    input wire logic [1:0] xmap_i,
    input wire logic xmux_i,
    // program space access
    input wire logic pacc_i,
    input wire logic pacc_data_i,
    input wire logic [17:0] paddr_i,
    // outputs
    output logic [2:0] tgt_o,
    output logic [7:0] iram_addr_o,
    output logic [2:0] bit_pos_o,
    output logic bit_acc_o,
    output logic [12:0] xmem_addr_o,
    output logic [15:0] ext_addr_o,
    output logic ext_mux_o,
    output logic [7:0] flash_sector_o,
    output logic [17:0] flash_addr_o,
    output logic flash_reserved_o
);
    dmad_tgt_t tgt_d, tgt_q;
    logic [7:0] iram_d, iram_q;
    logic [2:0] bitp_d, bitp_q;
    logic bita_d, bita_q;
    logic [12:0] xr_d, xr_q;
    logic [15:0] ex_d, ex_q;
    logic mux_d, mux_q;
    logic [7:0] sec_d, sec_q;
    logic [17:0] fa_d, fa_q;
    logic rsv_d, rsv_q;
    logic f_hit, f_rsv, f_scr;
    logic [7:0] f_sec;
    logic [7:0] bit_byte;

    dmad_flash_dec #(.BANKED(BANKED)) u_flash (
        .addr_i(paddr_i),
        .is_data_i(pacc_data_i),
        .hit_o(f_hit),
        .reserved_o(f_rsv),
        .scratch_o(f_scr),
        .sector_o(f_sec)
    );

    // bit address: low 128 bit numbers map into the 16-byte bit area
    assign bit_byte = DMAD_BANK_END + {4'h0, iaddr_i[6:3]};

    always_comb begin
        tgt_d = DMAD_TGT_NONE;
        iram_d = iram_q;
        bitp_d = bitp_q;
        bita_d = 1'b0;
        xr_d = xr_q;
        ex_d = ex_q;
        mux_d = xmux_i;
        sec_d = sec_q;
        fa_d = fa_q;
        rsv_d = 1'b0;
        // priority gives one target per cycle
        if (iacc_i) begin
            if (iacc_bit_i && !iaddr_i[7]) begin
                tgt_d = DMAD_TGT_IRAM;
                iram_d = bit_byte;
                bitp_d = iaddr_i[2:0];
                bita_d = 1'b1;
            end else if (iacc_bit_i || (iacc_direct_i && iaddr_i[7])) begin
                tgt_d = DMAD_TGT_SPECIAL;
                iram_d = iaddr_i;
                bitp_d = iaddr_i[2:0];
                bita_d = iacc_bit_i;
            end else if (iaddr_i < DMAD_BANK_END) begin
                tgt_d = DMAD_TGT_IRAM;
                iram_d = {3'h0, bank_sel_i, iaddr_i[2:0]};
            end else begin
                tgt_d = DMAD_TGT_IRAM;
                iram_d = iaddr_i;
            end
        end else if (xacc_i) begin
            unique case (dmad_map_t'(xmap_i))
                DMAD_MAP_ONCHIP: begin
                    tgt_d = DMAD_TGT_XMEM_ONCHIP;
                    xr_d = xaddr_i[12:0];
                end
                DMAD_MAP_OFFCHIP: begin
                    tgt_d = DMAD_TGT_EXT_PORT;
                    ex_d = xaddr_i;
                end
                DMAD_MAP_SPLIT, DMAD_MAP_SPLIT2: begin
                    if (xaddr_i < DMAD_XMEM_SIZE) begin
                        tgt_d = DMAD_TGT_XMEM_ONCHIP;
                        xr_d = xaddr_i[12:0];
                    end else begin
                        tgt_d = DMAD_TGT_EXT_PORT;
                        ex_d = xaddr_i;
                    end
                end
            endcase
        end else if (pacc_i) begin
            fa_d = paddr_i;
            sec_d = f_sec;
            rsv_d = f_rsv;
            if (f_scr) begin
                tgt_d = DMAD_TGT_SCRATCH;
            end else if (f_hit) begin
                tgt_d = DMAD_TGT_FLASH;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tgt_q <= DMAD_TGT_NONE;
            iram_q <= 8'h00;
            bitp_q <= 3'h0;
            bita_q <= 1'b0;
            xr_q <= 13'h0000;
            ex_q <= 16'h0000;
            mux_q <= 1'b0;
            sec_q <= 8'h00;
            fa_q <= 18'h00000;
            rsv_q <= 1'b0;
        end else if (ce_i) begin
            tgt_q <= tgt_d;
            iram_q <= iram_d;
            bitp_q <= bitp_d;
            bita_q <= bita_d;
            xr_q <= xr_d;
            ex_q <= ex_d;
            mux_q <= mux_d;
            sec_q <= sec_d;
            fa_q <= fa_d;
            rsv_q <= rsv_d;
        end
    end

    assign tgt_o = tgt_q;
    assign iram_addr_o = iram_q;
    assign bit_pos_o = bitp_q;
    assign bit_acc_o = bita_q;
    assign xmem_addr_o = xr_q;
    assign ext_addr_o = ex_q;
    assign ext_mux_o = mux_q;
    assign flash_sector_o = sec_q;
    assign flash_addr_o = fa_q;
    assign flash_reserved_o = rsv_q;

    a_upper_indirect: assert property (@(posedge clk_i) disable iff (!rstn_i)
        ce_i && iacc_i && !iacc_direct_i && !iacc_bit_i && iaddr_i[7]
        |=> tgt_o == DMAD_TGT_IRAM && iram_addr_o == $past(iaddr_i))
        else $error("upper indirect not to ram");
    a_upper_direct: assert property (@(posedge clk_i) disable iff (!rstn_i)
        ce_i && iacc_i && iacc_direct_i && !iacc_bit_i && iaddr_i[7]
        |=> tgt_o == DMAD_TGT_SPECIAL)
        else $error("upper direct not to special space");
    a_lower_both: assert property (@(posedge clk_i) disable iff (!rstn_i)
        ce_i && iacc_i && !iacc_bit_i && !iaddr_i[7]
        |=> tgt_o == DMAD_TGT_IRAM)
        else $error("lower half not ram");
    a_bank_map: assert property (@(posedge clk_i) disable iff (!rstn_i)
        ce_i && iacc_i && !iacc_bit_i && iaddr_i < 8'h20
        |=> iram_addr_o[4:3] == $past(bank_sel_i))
        else $error("bank select ignored");
    a_bit_area: assert property (@(posedge clk_i) disable iff (!rstn_i)
        ce_i && iacc_i && iacc_bit_i && !iaddr_i[7]
        |=> iram_addr_o >= 8'h20 && iram_addr_o < 8'h30 && bit_acc_o)
        else $error("bit access outside bit area");
    a_xmem_alias: assert property (@(posedge clk_i) disable iff (!rstn_i)
        ce_i && !iacc_i && xacc_i && xmap_i == 2'h0
        |=> tgt_o == DMAD_TGT_XMEM_ONCHIP
            && xmem_addr_o == $past(xaddr_i[12:0]))
        else $error("onchip alias wrong");
    a_split_map: assert property (@(posedge clk_i) disable iff (!rstn_i)
        ce_i && !iacc_i && xacc_i && xmap_i[1] && xaddr_i >= 16'h2000
        |=> tgt_o == DMAD_TGT_EXT_PORT)
        else $error("split high not external");
    a_reserved: assert property (@(posedge clk_i) disable iff (!rstn_i)
        ce_i && !iacc_i && !xacc_i && pacc_i && BANKED
        && paddr_i >= 18'h1fc00 && paddr_i <= 18'h1ffff
        |=> flash_reserved_o && tgt_o != DMAD_TGT_FLASH)
        else $error("reserved flash reachable");

    a_split_low: assert property (@(posedge clk_i) disable iff (!rstn_i)
        ce_i && !iacc_i && xacc_i && xmap_i[1] && xaddr_i < DMAD_XMEM_SIZE
        |=> tgt_o == DMAD_TGT_XMEM_ONCHIP
            && xmem_addr_o == $past(xaddr_i[12:0]))
        else $error("split low not onchip");
    a_offchip_map: assert property (@(posedge clk_i) disable iff (!rstn_i)
        ce_i && !iacc_i && xacc_i && xmap_i == 2'h1
        |=> tgt_o == DMAD_TGT_EXT_PORT
            && ext_addr_o == $past(xaddr_i))
        else $error("offchip access not external");
    a_mux_follow: assert property (@(posedge clk_i) disable iff (!rstn_i)
        ce_i |=> ext_mux_o == $past(xmux_i))
        else $error("port line mode not followed");
    a_bit_pos: assert property (@(posedge clk_i) disable iff (!rstn_i)
        ce_i && iacc_i && iacc_bit_i
        |=> bit_acc_o && bit_pos_o == $past(iaddr_i[2:0]))
        else $error("bit position lost");
    a_flash_hit: assert property (@(posedge clk_i) disable iff (!rstn_i)
        ce_i && !iacc_i && !xacc_i && pacc_i && paddr_i < DMAD_RSV_LO
        && (BANKED || paddr_i <= DMAD_SMALL_END)
        |=> tgt_o == DMAD_TGT_FLASH && !flash_reserved_o)
        else $error("user flash not reached");
    a_sector_num: assert property (@(posedge clk_i) disable iff (!rstn_i)
        ce_i && !iacc_i && !xacc_i && pacc_i && paddr_i < DMAD_SCR_LO
        |=> flash_sector_o == $past(paddr_i[17:10]))
        else $error("flash sector wrong");
    a_scratch_data: assert property (@(posedge clk_i) disable iff (!rstn_i)
        ce_i && !iacc_i && !xacc_i && pacc_i
        && paddr_i >= DMAD_SCR_LO && paddr_i <= DMAD_SCR_HI
        |=> (tgt_o == DMAD_TGT_SCRATCH) == $past(pacc_data_i)
            && flash_reserved_o != $past(pacc_data_i))
        else $error("scratchpad not data only");
    a_idle_none: assert property (@(posedge clk_i) disable iff (!rstn_i)
        ce_i && !iacc_i && !xacc_i && !pacc_i
        |=> tgt_o == DMAD_TGT_NONE && !flash_reserved_o)
        else $error("target without access");
    a_ce_freeze: assert property (@(posedge clk_i) disable iff (!rstn_i)
        !ce_i |=> $stable(tgt_o) && $stable(iram_addr_o)
            && $stable(flash_addr_o) && $stable(ext_addr_o))
        else $error("state moved while frozen");
endmodule

// file: sim/dmad_core_model.sv
// processor core model that launches one decoder request per cycle
`timescale 1ns/10ps
module dmad_core_model (
    input wire logic clk_i,
    input wire logic [52:0] cmd_i,
    output logic [52:0] req_o
);
    initial req_o = '0;
    // requests move only just after the edge, never at it
    always @(posedge clk_i) begin
        req_o <= #1 cmd_i;
    end
endmodule

// file: sim/tb.sv
// self-checking bench for the memory address decoder
`timescale 1ns/10ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_total++; \
    $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module tb;
    import dmad_pkg::*;
    typedef struct packed {
        logic [2:0] tgt;
        logic rsv;
        logic bacc;
        logic [2:0] bpos;
        logic [7:0] iram;
        logic [12:0] xmem;
        logic [15:0] ext;
        logic mux;
        logic [7:0] sec;
        logic [17:0] fa;
    } dmad_exp_t;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic ce_n = 1'b1;
    logic ce = 1'b1;
    logic [52:0] cmd = '0;
    logic [52:0] req;
    logic [63:0] t;
    logic [2:0] tgt_o, bit_pos_o;
    logic [7:0] iram_addr_o, flash_sector_o;
    logic [12:0] xmem_addr_o;
    logic [15:0] ext_addr_o;
    logic [17:0] flash_addr_o;
    logic bit_acc_o, ext_mux_o, flash_reserved_o;
    logic [17:0] corner [4] = '{18'h1fc00, 18'h1ffff, 18'h20000, 18'h200ff};
    dmad_exp_t e0 = '0, e1 = '0;
    int seed = 23186;
    int err_total = 0;
    int cmp_count = 0;
    initial forever #4 clk = ~clk;
    dmad_core_model u_core (.clk_i(clk), .cmd_i(cmd), .req_o(req));
    // enable travels with its request through the same one-cycle delay
    always @(posedge clk) ce <= #1 ce_n;
    dmad_top #(.BANKED(1'b1)) u_dut (.clk_i(clk), .rstn_i(rstn), .ce_i(ce),
        .iacc_i(req[52]), .iacc_direct_i(req[51]), .iacc_bit_i(req[50]),
        .iaddr_i(req[49:42]), .bank_sel_i(req[41:40]), .xacc_i(req[39]),
        .xaddr_i(req[38:23]), .xmap_i(req[22:21]), .xmux_i(req[20]),
        .pacc_i(req[19]), .pacc_data_i(req[18]), .paddr_i(req[17:0]),
        .tgt_o(tgt_o), .iram_addr_o(iram_addr_o), .bit_pos_o(bit_pos_o),
        .bit_acc_o(bit_acc_o), .xmem_addr_o(xmem_addr_o),
        .ext_addr_o(ext_addr_o), .ext_mux_o(ext_mux_o),
        .flash_sector_o(flash_sector_o), .flash_addr_o(flash_addr_o),
        .flash_reserved_o(flash_reserved_o));
    function automatic dmad_exp_t f_exp(logic [52:0] c);
        dmad_exp_t e;
        e = '0;
        if (c[52]) begin
            if (c[50]) begin
                e.bacc = 1'b1;
                e.bpos = c[44:42];
                e.tgt = c[49] ? DMAD_TGT_SPECIAL : DMAD_TGT_IRAM;
                e.iram = 8'h20 + {4'h0, c[48:45]};
            end else if (c[49] && c[51]) begin
                e.tgt = DMAD_TGT_SPECIAL;
            end else begin
                e.tgt = DMAD_TGT_IRAM;
                e.iram = (c[49:42] < 8'h20) ? {3'h0, c[41:40], c[44:42]}
                                            : c[49:42];
            end
        end else if (c[39]) begin
            e.mux = c[20];
            e.xmem = c[35:23];
            e.ext = c[38:23];
            e.tgt = (c[22:21] == 2'h0 ||
                     (c[22:21] != 2'h1 && c[38:23] < DMAD_XMEM_SIZE))
                    ? DMAD_TGT_XMEM_ONCHIP : DMAD_TGT_EXT_PORT;
        end else if (c[19]) begin
            e.fa = c[17:0];
            e.sec = c[17:10];
            if (c[17:0] >= DMAD_RSV_LO && c[17:0] <= DMAD_RSV_HI) begin
                e.rsv = 1'b1;
            end else if (c[17:0] >= DMAD_SCR_LO) begin
                if (c[18]) e.tgt = DMAD_TGT_SCRATCH;
                else e.rsv = 1'b1;
            end else begin
                e.tgt = DMAD_TGT_FLASH;
            end
        end
        return e;
    endfunction
    task automatic test_done();
        if (err_total == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        #(8 * 6000);
        err_total++;
        test_done();
    end
    initial begin
        repeat (16) @(posedge clk);
        `CHK(tgt_o, 3'h0)
        #1 rstn = 1'b1;
        for (int i = 0; i < 5000; i++) begin
            @(posedge clk);
            #2;
            `CHK(tgt_o, e1.tgt)
            `CHK(bit_acc_o, e1.bacc)
            `CHK(flash_reserved_o, e1.rsv)
            if (e1.bacc) `CHK(bit_pos_o, e1.bpos)
            if (e1.tgt == DMAD_TGT_IRAM) `CHK(iram_addr_o, e1.iram)
            if (e1.tgt == DMAD_TGT_XMEM_ONCHIP) `CHK(xmem_addr_o, e1.xmem)
            if (e1.tgt == DMAD_TGT_EXT_PORT) begin
                `CHK(ext_addr_o, e1.ext)
                `CHK(ext_mux_o, e1.mux)
            end
            if (e1.tgt == DMAD_TGT_FLASH) `CHK(flash_sector_o, e1.sec)
            if (e1.tgt == DMAD_TGT_FLASH) `CHK(flash_addr_o, e1.fa)
            if (e1.tgt == DMAD_TGT_SCRATCH) `CHK(flash_addr_o, e1.fa)
            e1 = e0;
            t = {$random(seed), $random(seed)};
            cmd = t[52:0];
            // about one cycle in eight is frozen by a low enable
            ce_n = (t[58:56] != 3'h0);
            cmd[17:0] = t[17:0] % 18'h20100;
            // steer some program accesses onto the area edges
            if (t[63:61] == 3'h0) cmd[17:0] = corner[t[60:59]];
            e0 = ce_n ? f_exp(cmd) : e0;
        end
        test_done();
    end
endmodule
